// ===== design/pcc_countdown.sv
// Pedestrian clearance countdown controller: phase watcher, learning and digit drive.
module pcc_countdown
   import pcc_pkg::*;
#(
   parameter int MS_CYCLES = pcc_pkg::MS_CYCLES_DEF
)(
   input  wire logic       CLOCK,
   input  wire logic       RST_B,
   input  wire logic       WALK_IN,
   input  wire logic       HAND_IN,
   input  wire logic       SUPPLY_OK,
   output pcc_pkg::pcc_disp_t DISPLAY
);
   import pcc_pkg::*;

   // ------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------
   logic [2:0]  sync1;
   logic [2:0]  sync2;
   logic        walk_s;
   logic        hand_s;
   logic        supply_s;

   // Pins are asynchronous to CLOCK, so each passes two flip-flops.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end else begin
         sync1 <= {SUPPLY_OK, HAND_IN, WALK_IN};
         sync2 <= sync1;
      end
   end
   assign walk_s   = sync2[0];
   assign hand_s   = sync2[1];
   assign supply_s = sync2[2];

   // ------------------------------------------------------------------
   // Millisecond time base
   // ------------------------------------------------------------------
   logic [16:0] pre_cnt;
   logic        ms_tick;

   // A one-cycle enable every millisecond; all slow timing runs on it.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         pre_cnt <= 17'h0;
         ms_tick <= 1'b0;
      end else if (pre_cnt == 17'(MS_CYCLES - 1)) begin
         pre_cnt <= 17'h0;
         ms_tick <= 1'b1;
      end else begin
         pre_cnt <= pre_cnt + 17'h1;
         ms_tick <= 1'b0;
      end
   end

   // ------------------------------------------------------------------
   // Phase classification
   // ------------------------------------------------------------------
   pcc_phase_t  phase;
   pcc_phase_t  prev;
   pcc_phase_t  next_phase;
   logic        hand_d;
   logic [10:0] since_edge;
   logic        hand_edge;
   logic        hand_rise;

   assign hand_edge = hand_s != hand_d;
   assign hand_rise = hand_s && !hand_d;

   // Milliseconds since the last hand edge or active walk, saturating at the window.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         hand_d     <= 1'b0;
         since_edge <= 11'h0;
      end else begin
         hand_d <= hand_s;
         if (hand_edge || walk_s) begin
            since_edge <= 11'h0;
         end else if (ms_tick && since_edge < FLASH_WIN_MS) begin
            since_edge <= since_edge + 11'h1;
         end
      end
   end

   // Steady hand is only recognised a full window after its last rise, so the
   // digits blank that late; the trade buys immunity to a slow flash rate.
   always_comb begin
      next_phase = phase;
      if (walk_s) begin
         next_phase = PH_WALK;
      end else if (hand_s && since_edge >= FLASH_WIN_MS) begin
         next_phase = PH_STEADY;
      end else if (!hand_s && since_edge >= FLASH_WIN_MS) begin
         next_phase = PH_DARK;
      end else if (hand_rise && phase == PH_WALK) begin
         next_phase = PH_FLASH;
      end else if (hand_edge && !hand_s && phase != PH_WALK) begin
         next_phase = PH_FLASH;
      end
   end

   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         phase <= PH_DARK;
         prev  <= PH_DARK;
      end else begin
         phase <= next_phase;
         prev  <= phase;
      end
   end

   // ------------------------------------------------------------------
   // Seconds within the current phase
   // ------------------------------------------------------------------
   logic [9:0]  ms_in_sec;
   logic [6:0]  sec_cnt;
   logic        sec_tick;
   logic        phase_chg;

   assign phase_chg = phase != prev;
   assign sec_tick  = ms_tick && ms_in_sec == SEC_MS;

   // Restarting at each phase change makes the first decrement land one second in.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         ms_in_sec <= 10'h0;
         sec_cnt   <= 7'h0;
      end else if (phase_chg) begin
         ms_in_sec <= 10'h0;
         sec_cnt   <= 7'h0;
      end else if (sec_tick) begin
         ms_in_sec <= 10'h0;
         if (sec_cnt != SEC_MAX) begin
            sec_cnt <= sec_cnt + 7'h1;
         end
      end else if (ms_tick) begin
         ms_in_sec <= ms_in_sec + 10'h1;
      end
   end

   // ------------------------------------------------------------------
   // Learning, change detection and outage supervision
   // ------------------------------------------------------------------
   pcc_state_t  st;
   logic [6:0]  learned_clear;
   logic [6:0]  learned_walk;
   logic [6:0]  walk_len;
   logic [6:0]  meas;
   logic        preempt;
   logic [10:0] out_ms;
   logic        walk_end;
   logic        flash_end;
   logic        outage;
   logic        change;
   logic [6:0]  now_sec;

   // True when a exceeds b by more than the tolerance.
   function automatic logic exceeds(input logic [6:0] a, input logic [6:0] b);
      exceeds = {1'b0, a} > ({1'b0, b} + {1'b0, TOL_S});
   endfunction : exceeds

   // Phase time rounded to the nearest second, so an interval that ends right on a
   // second boundary is not cut short by the one-cycle restart of the second counter.
   function automatic logic [6:0] whole_sec(input logic [6:0] s, input logic [9:0] ms);
      whole_sec = (s != SEC_MAX && ms > (SEC_MS >> 1)) ? s + 7'h1 : s;
   endfunction : whole_sec

   assign now_sec   = whole_sec(sec_cnt, ms_in_sec);
   assign walk_end  = prev == PH_WALK && phase != PH_WALK;
   assign flash_end = prev == PH_FLASH && (phase == PH_STEADY || phase == PH_WALK);
   assign outage    = !supply_s && out_ms > OUTAGE_MS;

   // A longer clearance is caught at a hand rise past the learned value; the steady
   // detection lag cannot trip it, since no rise follows the last one. A shorter one
   // is caught when the flash ends.
   assign change = st == ST_SHOW && (
      (phase == PH_WALK && !phase_chg && exceeds(sec_cnt, learned_walk)) ||
      (phase == PH_FLASH && hand_rise && !preempt &&
       exceeds(now_sec, learned_clear)) ||
      (flash_end && !preempt &&
       (exceeds(meas, learned_clear) || exceeds(learned_clear, meas))));

   // Length of supply loss in milliseconds, saturating just past the limit.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         out_ms <= 11'h0;
      end else if (supply_s) begin
         out_ms <= 11'h0;
      end else if (ms_tick && out_ms <= OUTAGE_MS) begin
         out_ms <= out_ms + 11'h1;
      end
   end

   // Clearance length ends at the last hand rise or at a recycling walk.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         meas     <= 7'h0;
         walk_len <= 7'h0;
         preempt  <= 1'b0;
      end else begin
         if (phase == PH_FLASH && (hand_rise || next_phase == PH_WALK)) begin
            meas <= now_sec;
         end
         if (walk_end) begin
            walk_len <= now_sec;
            preempt  <= st == ST_SHOW && exceeds(learned_walk, now_sec);
         end
      end
   end

   // WAIT and MEASURE keep the digits dark for one whole walk-to-clearance cycle.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         st            <= ST_WAIT;
         learned_clear <= 7'h0;
         learned_walk  <= 7'h0;
      end else if (outage) begin
         st <= ST_WAIT;
      end else begin
         unique case (st)
            ST_WAIT: begin
               if (phase == PH_WALK && phase_chg) begin
                  st <= ST_MEASURE;
               end
            end
            ST_MEASURE: begin
               if (flash_end) begin
                  learned_clear <= (meas > COUNT_MAX) ? COUNT_MAX : meas;
                  learned_walk  <= walk_len;
                  st            <= ST_SHOW;
               end else if (phase == PH_DARK || (phase == PH_STEADY && prev == PH_WALK)) begin
                  st <= ST_WAIT;
               end
            end
            ST_SHOW: begin
               if (change) begin
                  st <= ST_WAIT;
               end
            end
            default: begin
               st <= ST_WAIT;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Digit drive
   // ------------------------------------------------------------------
   logic [6:0]  cnt_now;
   logic        show_now;

   assign cnt_now  = (sec_cnt >= learned_clear) ? 7'h0 : learned_clear - sec_cnt;
   // The first flash cycle still holds the walk's second count, so the digits wait one cycle.
   assign show_now = st == ST_SHOW && phase == PH_FLASH && !phase_chg &&
                     supply_s && !change;

   // Digits are lit as a plain level only in clearance, so they never follow
   // the hand flash and need no modulation at all.
   always_ff @(posedge CLOCK or negedge RST_B) begin
      if (!RST_B) begin
         DISPLAY <= '0;
      end else begin
         DISPLAY.on    <= show_now;
         DISPLAY.tens  <= 4'(cnt_now / 7'h0A);
         DISPLAY.units <= 4'(cnt_now % 7'h0A);
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_B);

   property p_only_clear;
      DISPLAY.on |-> $past(phase) == PH_FLASH && $past(st) == ST_SHOW;
   endproperty
   a_only_clear: assert property (p_only_clear) else $error("Digits lit outside clearance.");

   property p_dec;
      (sec_tick && !phase_chg && phase == PH_FLASH && cnt_now != 7'h0) |=>
         cnt_now == $past(cnt_now) - 7'h1;
   endproperty
   a_dec: assert property (p_dec) else $error("Count did not step down by one.");

   property p_learn_dark;
      st != ST_SHOW |=> !DISPLAY.on;
   endproperty
   a_learn_dark: assert property (p_learn_dark) else $error("Digits lit while learning.");

   property p_change;
      change |=> st == ST_WAIT ##1 !DISPLAY.on;
   endproperty
   a_change: assert property (p_change) else $error("Timing change did not blank.");

   property p_recycle;
      (st == ST_SHOW && flash_end && phase == PH_WALK && !change && supply_s) |=> st == ST_SHOW;
   endproperty
   a_recycle: assert property (p_recycle) else $error("Recycle left the show state.");

   property p_lit;
      (st == ST_SHOW && phase == PH_FLASH && !phase_chg && supply_s && !change) |=> DISPLAY.on;
   endproperty
   a_lit: assert property (p_lit) else $error("Digits dark during clearance.");

   property p_keep;
      st == ST_SHOW |=> learned_clear == $past(learned_clear);
   endproperty
   a_keep: assert property (p_keep) else $error("Learned value moved while showing.");

   property p_halt;
      (phase == PH_STEADY || phase == PH_DARK) |=> !DISPLAY.on;
   endproperty
   a_halt: assert property (p_halt) else $error("Digits lit on steady or dark.");

   property p_outage;
      outage |=> st == ST_WAIT ##1 !DISPLAY.on;
   endproperty
   a_outage: assert property (p_outage) else $error("Long outage did not restart learning.");

   property p_bcd;
      DISPLAY.tens <= 4'h9 && DISPLAY.units <= 4'h9;
   endproperty
   a_bcd: assert property (p_bcd) else $error("Digit out of decimal range.");

   property p_steady;
      (hand_s && !walk_s && since_edge >= FLASH_WIN_MS) |=> phase == PH_STEADY;
   endproperty
   a_steady: assert property (p_steady) else $error("Uninterrupted hand not steady.");

   c_learned: cover property (st == ST_MEASURE ##1 st == ST_SHOW);
   c_zero:    cover property (DISPLAY.on && DISPLAY.tens == 4'h0 && DISPLAY.units == 4'h0);
   c_relearn: cover property (change);
   c_outage:  cover property (outage);

endmodule : pcc_countdown

// ===== shared/pcc_pkg.sv
// Constants and types shared by the pedestrian clearance countdown controller.
package pcc_pkg;

   // ------------------------------------------------------------------
   // Time base
   // ------------------------------------------------------------------
   localparam int          CLK_HZ        = 125_000_000;
   localparam int          MS_PER_S      = 1000;
   localparam int          MS_CYCLES_DEF = CLK_HZ / MS_PER_S;  // Cycles per millisecond.
   localparam logic [9:0]  SEC_MS        = 10'h3E7;            // Last ms of a second (999).
   localparam logic [10:0] FLASH_WIN_MS  = 11'h5DC;            // Hand toggle window, 1500 ms.
   localparam logic [10:0] OUTAGE_MS     = 11'h7D0;            // Supply loss limit, 2000 ms.

   // ------------------------------------------------------------------
   // Counts and display limits
   // ------------------------------------------------------------------
   localparam logic [6:0]  SEC_MAX       = 7'h7F;   // Phase second counter saturates here.
   localparam logic [6:0]  COUNT_MAX     = 7'h63;   // Largest displayable count, 99.
   localparam logic [6:0]  TOL_S         = 7'h01;   // Tolerance before timing counts as changed.

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      PH_DARK   = 2'h0,
      PH_WALK   = 2'h1,
      PH_FLASH  = 2'h3,
      PH_STEADY = 2'h2
   } pcc_phase_t;

   typedef enum logic [1:0] {
      ST_WAIT    = 2'h0,
      ST_MEASURE = 2'h1,
      ST_SHOW    = 2'h3
   } pcc_state_t;

   typedef struct packed {
      logic       on;
      logic [3:0] tens;
      logic [3:0] units;
   } pcc_disp_t;

endpackage : pcc_pkg

// ===== tb/pcc_sig_ctl.sv
// Behavioural traffic signal controller driving the walk and hand load switch outputs.
module pcc_sig_ctl #(
   parameter int MS_CYCLES = 2
)(
   input  wire logic clock,
   output logic      walk_on,
   output logic      hand_on
);
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------
   // Phase drive
   // ------------------------------------------------------------------
   // Both load switches start dark, as after a cold start of the cabinet.
   initial begin
      walk_on = 1'b0;
      hand_on = 1'b0;
   end

   // Outputs change one step after an edge and hold for whole milliseconds.
   task automatic drive(input logic w, input logic h, input int ms);
      walk_on = w;
      hand_on = h;
      repeat (ms * MS_CYCLES) @(posedge clock);
      #1;
   endtask : drive

   // Flashing hand in 500 ms halves, lit first; a short last half models preemption.
   task automatic flash(input int ms);
      int t;
      for (t = 0; t < ms; t += 500) begin
         drive(1'b0, ((t / 500) % 2) == 0, (ms - t < 500) ? ms - t : 500);
      end
   endtask : flash

   // One pedestrian cycle; a zero steady time recycles straight into the next walk.
   task automatic cycle(input int walk_ms, input int flash_ms, input int steady_ms);
      drive(1'b1, 1'b0, walk_ms);
      flash(flash_ms);
      if (steady_ms > 0) begin
         drive(1'b0, 1'b1, steady_ms);
      end
   endtask : cycle

endmodule : pcc_sig_ctl

// ===== tb/tb.sv
// Self-checking bench for the pedestrian clearance countdown controller.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pcc_pkg::*;

   // One millisecond is one clock, so a second is 1000 cycles and the run stays short.
   localparam int MSC         = 1;
   // The scenarios take about 75,000 cycles; the ceiling leaves some margin.
   localparam int CYCLE_LIMIT = 90000;

   logic        clock;
   logic        rst_b;
   logic        supply_ok;
   logic        walk_on;
   logic        hand_on;
   pcc_disp_t   display;
   pcc_disp_t   exp_q[$];
   pcc_disp_t   seen;
   pcc_disp_t   last;
   pcc_disp_t   want;
   int          err_total;
   int          comparisons;
   int          cycles;
   logic [31:0] seed;

   // ------------------------------------------------------------------
   // Clock and instances
   // ------------------------------------------------------------------
   // Free running 125 MHz clock.
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   pcc_countdown #(.MS_CYCLES(MSC)) u_dut (
      .CLOCK     (clock),
      .RST_B     (rst_b),
      .WALK_IN   (walk_on),
      .HAND_IN   (hand_on),
      .SUPPLY_OK (supply_ok),
      .DISPLAY   (display)
   );

   pcc_sig_ctl #(.MS_CYCLES(MSC)) u_ctl (
      .clock   (clock),
      .walk_on (walk_on),
      .hand_on (hand_on)
   );

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Xorshift generator; a fixed start keeps every run identical.
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   // Lit display showing a decimal count.
   function automatic pcc_disp_t digits(input int n);
      pcc_disp_t d;
      d.on = 1'b1;
      d.tens = 4'(n / 10);
      d.units = 4'(n % 10);
      return d;
   endfunction : digits

   // Every visible step of a countdown from hi to lo, then the blank.
   task automatic expect_down(input int hi, input int lo);
      for (int n = hi; n >= lo; n--) begin
         exp_q.push_back(digits(n));
      end
      exp_q.push_back(9'h000);
   endtask : expect_down

   task automatic check_disp(input pcc_disp_t got, input pcc_disp_t exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_disp

   task automatic check_cnt(input int got, input int exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check_cnt

   task automatic wrap_up();
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : wrap_up

   // ------------------------------------------------------------------
   // Output watcher
   // ------------------------------------------------------------------
   // Sampled on the falling edge, where the outputs have settled. A dark display hides
   // its digits, so any visible change, blinking included, pops a note.
   always @(negedge clock) begin
      cycles++;
      if (cycles >= CYCLE_LIMIT) begin
         err_total++;
         wrap_up();
      end else if (rst_b === 1'b1) begin
         seen = (display.on === 1'b0) ? 9'h000 : display;
         if (seen !== last) begin
            last = seen;
            want = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
            check_disp(seen, want);
         end
      end
   end

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Learned clearance is 4 s with a 2 s walk; later cycles stress it.
   initial begin
      rst_b = 1'b0;
      supply_ok = 1'b1;
      seed = 32'd27772;
      err_total = 0;
      comparisons = 0;
      cycles = 0;
      last = 9'h000;
      repeat (10) @(posedge clock);
      #1;
      rst_b = 1'b1;
      u_ctl.cycle(2000, 4000, 1800);
      expect_down(4, 1);
      u_ctl.cycle(2000, 3750, 0);
      expect_down(4, 0);
      u_ctl.cycle(2000, 4000, 1800);
      // A short supply dip on steady hand must not force relearning.
      seed = xs(seed);
      supply_ok = 1'b0;
      u_ctl.drive(1'b0, 1'b1, 1 + int'(seed % 400));
      supply_ok = 1'b1;
      u_ctl.drive(1'b0, 1'b1, 200);
      expect_down(4, 1);
      u_ctl.cycle(300, 2500, 1800);
      expect_down(4, 0);
      u_ctl.cycle(2000, 7000, 1800);
      u_ctl.cycle(2000, 7000, 1800);
      expect_down(7, 0);
      u_ctl.cycle(2000, 7000, 1800);
      // A supply loss past the limit forces one dark learning cycle before counts return.
      supply_ok = 1'b0;
      u_ctl.drive(1'b0, 1'b1, 2100);
      supply_ok = 1'b1;
      u_ctl.cycle(2000, 3000, 1800);
      expect_down(3, 0);
      u_ctl.cycle(2000, 3000, 1800);
      check_cnt(exp_q.size(), 0);
      wrap_up();
   end

endmodule : tb
